// >>> core/hpi_irq_latch.sv
// Top: input-full requests to slave CPU and host request latches in port four
`timescale 1ns/1ps
`default_nettype none
module hpi_irq_latch
	import hpi_pkg::*;
(
	input wire logic I_CORE_CLK,
	input wire logic I_RSTN,
	input wire logic I_CE,
	input wire logic I_INPUT_FULL_IRQ_EN_A,
	input wire logic I_INPUT_FULL_IRQ_EN_B,
	input wire logic I_HOST_IN_REG_A_FULL,
	input wire logic I_HOST_IN_REG_B_FULL,
	input wire logic I_HOST_IFACE_ENABLE,
	input wire logic I_PORT_WR,
	input wire logic [HPI_DW-1:0] I_PORT_WDATA,
	input wire logic I_PORT_RD,
	input wire logic I_HOST_SELECT_A_N,
	input wire logic I_HOST_SELECT_B_N,
	input wire logic I_HOST_ADDR_BIT,
	input wire logic I_HOST_READ_STROBE_N,
	output logic O_INPUT_FULL_IRQ_A,
	output logic O_INPUT_FULL_IRQ_B,
	output logic [HPI_DW-1:0] O_PORT_RDATA,
	output logic O_HOST_REQ_LATCH_B,
	output logic O_HOST_REQ_LATCH_A0,
	output logic O_HOST_REQ_LATCH_A1
);
	typedef struct packed {
		logic irq_a;
		logic irq_b;
		logic [HPI_DW-1:0] port;
		logic [HPI_DW-1:0] rdata;
		logic [HPI_DW-1:0] seen0;
	} hpi_state_t;
	hpi_state_t cur;
	hpi_state_t next_cur;
	hpi_link_if link ();
	hpi_host_decode u_dec (
		.i_clk(I_CORE_CLK),
		.i_rstn(I_RSTN),
		.i_ce(I_CE),
		.i_sel_a_n(I_HOST_SELECT_A_N),
		.i_sel_b_n(I_HOST_SELECT_B_N),
		.i_addr(I_HOST_ADDR_BIT),
		.i_rd_n(I_HOST_READ_STROBE_N),
		.link(link.src)
	);
	always_comb
	begin
		next_cur = cur;
		next_cur.irq_a = I_INPUT_FULL_IRQ_EN_A & I_HOST_IN_REG_A_FULL;
		next_cur.irq_b = I_INPUT_FULL_IRQ_EN_B & I_HOST_IN_REG_B_FULL;
		if (I_PORT_RD)
		begin
			next_cur.rdata = cur.port;
			// Remember bits read as 0 so a later write of 1 may set them
			next_cur.seen0 = ~cur.port;
		end
		if (I_PORT_WR)
		begin
			for (int i = 0; i < HPI_DW; i++)
			begin
				if (!I_PORT_WDATA[i])
				begin
					next_cur.port[i] = 1'b0;
				end
				// With the interface enabled, only the three latch bits need the read-0 first; others are plain storage
				else if (cur.seen0[i] || !I_HOST_IFACE_ENABLE || (i != HPI_BIT_B
					&& i != HPI_BIT_A0 && i != HPI_BIT_A1))
				begin
					next_cur.port[i] = 1'b1;
				end
			end
			next_cur.seen0 = '0;
		end
		// Host read clears only in slave mode; slave set is lost if same cycle
		if (I_HOST_IFACE_ENABLE)
		begin
			if (link.read_b)
			begin
				next_cur.port[HPI_BIT_B] = 1'b0;
			end
			if (link.read_a)
			begin
				next_cur.port[HPI_BIT_A0] = 1'b0;
				next_cur.port[HPI_BIT_A1] = 1'b0;
			end
		end
	end
	always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			cur <= '{irq_a: 1'b0, irq_b: 1'b0, port: HPI_PORT_RST, rdata: HPI_PORT_RST,
				seen0: HPI_PORT_RST};
		end
		else if (I_CE)
		begin
			cur <= next_cur;
		end
	end
	assign O_INPUT_FULL_IRQ_A = cur.irq_a;
	assign O_INPUT_FULL_IRQ_B = cur.irq_b;
	assign O_PORT_RDATA = cur.rdata;
	// Latch pins follow the port bits in every mode
	assign O_HOST_REQ_LATCH_B = cur.port[HPI_BIT_B];
	assign O_HOST_REQ_LATCH_A0 = cur.port[HPI_BIT_A0];
	assign O_HOST_REQ_LATCH_A1 = cur.port[HPI_BIT_A1];
endmodule
`default_nettype wire

// >>> core/hpi_pkg.sv
// Package with constants and rule notes for the host port interrupt latch block
// Notes on behaviour
// - Input-full request A is raised while its enable is 1 and input register A holds unread host data.
// - Input-full request B is raised while its enable is 1 and input register B holds unread host data.
// - The three port four bits act as host request latches only while the host interface enable is 1.
// - Latch at bit 3 sets when the slave reads 0 then writes 1, clears on a slave write of 0 or a host read of output register B.
// - Latch at bit 4 sets when the slave reads 0 then writes 1, clears on a slave write of 0 or a host read of output register A.
// - Latch at bit 5 sets when the slave reads 0 then writes 1, clears on a slave write of 0 or a host read of output register A.
// - A host output read clears latches when the read strobe falls with the chip select and address bit low.
// - Host and slave never access the same data register at once, since that corrupts the data.
// - A host read with address bit 0 returns the output register, with address bit 1 the status register.
package hpi_pkg;
	localparam int HPI_DW = 8;
	localparam int HPI_BIT_B = 3;
	localparam int HPI_BIT_A0 = 4;
	localparam int HPI_BIT_A1 = 5;
	localparam logic [7:0] HPI_PORT_RST = 8'h00;
	localparam logic [2:0] HPI_LATCH_RST = 3'h0;
	localparam logic [2:0] HPI_SYNC_RST = 3'h7;
endpackage

// >>> core/hpi_link_if.sv
// Interface carrying synchronised host strobes between top and edge detector
`timescale 1ns/1ps
`default_nettype none
interface hpi_link_if;
	logic read_a;
	logic read_b;
	modport src (output read_a, output read_b);
	modport dst (input read_a, input read_b);
endinterface
`default_nettype wire

// >>> core/hpi_host_decode.sv
// Synchroniser and falling-edge decoder for host output register reads
`timescale 1ns/1ps
`default_nettype none
module hpi_host_decode
	import hpi_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_rstn,
	input wire logic i_ce,
	input wire logic i_sel_a_n,
	input wire logic i_sel_b_n,
	input wire logic i_addr,
	input wire logic i_rd_n,
	hpi_link_if.src link
);
	typedef struct packed {
		logic [2:0] s1;
		logic [2:0] s2;
		logic [2:0] s3;
		logic rd_a;
		logic rd_b;
	} hpi_dec_t;
	hpi_dec_t cur;
	hpi_dec_t next_cur;
	always_comb
	begin
		next_cur = cur;
		next_cur.s1 = {i_rd_n, i_sel_a_n | i_addr, i_sel_b_n | i_addr};
		next_cur.s2 = cur.s1;
		next_cur.s3 = cur.s2;
		// Strobe fall with select and address low; data read, not status
		next_cur.rd_a = cur.s3[2] & ~cur.s2[2] & ~cur.s2[1];
		next_cur.rd_b = cur.s3[2] & ~cur.s2[2] & ~cur.s2[0];
	end
	always_ff @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			cur <= '{s1: HPI_SYNC_RST, s2: HPI_SYNC_RST, s3: HPI_SYNC_RST, rd_a: 1'b0, rd_b: 1'b0};
		end
		else if (i_ce)
		begin
			cur <= next_cur;
		end
	end
	assign link.read_a = cur.rd_a;
	assign link.read_b = cur.rd_b;
endmodule
`default_nettype wire

// >>> sim/hpi_host_model.sv
// Host processor model driving the output register read pins
`timescale 1ns/1ps
`default_nettype none
module hpi_host_model (input wire logic clk, output logic sa_n, sb_n, ad, rd_n);
	initial {sa_n, sb_n, ad, rd_n} = 4'hF;
	// Select first, strobe later, then release both selects and invert the address bit when done
	task automatic rd(input logic b, input logic a);
		@(negedge clk) {sa_n, sb_n, ad} = {b, !b, a};
		@(negedge clk) rd_n = 1'b0;
		repeat (2) @(negedge clk);
		rd_n = 1'b1;
		@(negedge clk) {sa_n, sb_n, ad} = {1'b1, 1'b1, !a};
	endtask
endmodule
`default_nettype wire

// >>> sim/hpi_irq_latch_monitor.sv
// Checker on the ports of the host port interrupt latch block
`timescale 1ns/1ps
`default_nettype none
module hpi_irq_latch_monitor
	import hpi_pkg::*;
(
	input wire logic I_CORE_CLK, I_RSTN, I_CE, I_HOST_IFACE_ENABLE, I_PORT_WR,
	input wire logic I_INPUT_FULL_IRQ_EN_A, I_INPUT_FULL_IRQ_EN_B,
	input wire logic I_HOST_IN_REG_A_FULL, I_HOST_IN_REG_B_FULL,
	input wire logic [HPI_DW-1:0] I_PORT_WDATA,
	input wire logic I_HOST_SELECT_A_N, I_HOST_SELECT_B_N,
	input wire logic I_HOST_ADDR_BIT, I_HOST_READ_STROBE_N,
	input wire logic O_INPUT_FULL_IRQ_A, O_INPUT_FULL_IRQ_B,
	input wire logic O_HOST_REQ_LATCH_B, O_HOST_REQ_LATCH_A0, O_HOST_REQ_LATCH_A1
);
	default clocking @(posedge I_CORE_CLK); endclocking
	default disable iff (!I_RSTN);
	a_irq_a_level: assert property (I_CE |=> O_INPUT_FULL_IRQ_A ==
		$past(I_INPUT_FULL_IRQ_EN_A & I_HOST_IN_REG_A_FULL)) else $error("irq a wrong");
	a_irq_b_level: assert property (I_CE |=> O_INPUT_FULL_IRQ_B ==
		$past(I_INPUT_FULL_IRQ_EN_B & I_HOST_IN_REG_B_FULL)) else $error("irq b wrong");
	// Window covers the two sync stages plus edge and latch registers
	a_clear_a_read: assert property (I_HOST_IFACE_ENABLE && $fell(I_HOST_READ_STROBE_N)
		&& !I_HOST_SELECT_A_N && !I_HOST_ADDR_BIT |-> ##[3:5]
		!O_HOST_REQ_LATCH_A0 && !O_HOST_REQ_LATCH_A1) else $error("a latches kept");
	a_clear_b_read: assert property (I_HOST_IFACE_ENABLE && $fell(I_HOST_READ_STROBE_N)
		&& !I_HOST_SELECT_B_N && !I_HOST_ADDR_BIT |-> ##[3:5]
		!O_HOST_REQ_LATCH_B) else $error("b latch kept");
	a_set_b_write: assert property ($rose(O_HOST_REQ_LATCH_B) |->
		$past(I_PORT_WR && I_PORT_WDATA[HPI_BIT_B])) else $error("b set without write");
	a_set_a0_write: assert property ($rose(O_HOST_REQ_LATCH_A0) |->
		$past(I_PORT_WR && I_PORT_WDATA[HPI_BIT_A0])) else $error("a0 set without write");
	a_set_a1_write: assert property ($rose(O_HOST_REQ_LATCH_A1) |->
		$past(I_PORT_WR && I_PORT_WDATA[HPI_BIT_A1])) else $error("a1 set without write");
	a_plain_port_write: assert property (!I_HOST_IFACE_ENABLE && I_CE && I_PORT_WR |=>
		O_HOST_REQ_LATCH_B == $past(I_PORT_WDATA[HPI_BIT_B])) else $error("plain write lost");
	a_freeze_latches: assert property (!I_CE |=>
		$stable({O_HOST_REQ_LATCH_B, O_HOST_REQ_LATCH_A0, O_HOST_REQ_LATCH_A1}))
		else $error("latches moved while frozen");
endmodule
bind hpi_irq_latch hpi_irq_latch_monitor i_mon (.*);
`default_nettype wire

// >>> sim/tb.sv
// Self-checking bench for the host port interrupt latch block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hpi_pkg::*;
	logic clk = 1'b0, rstn = 1'b0, ce = 1'b1, host_iface_enable = 1'b0, wr = 1'b0, rd = 1'b0;
	logic [3:0] irq_in = 4'h0;
	logic [HPI_DW-1:0] wd = 8'h00;
	logic sa_n, sb_n, ad, rs_n;
	wire logic [12:0] got;
	logic [12:0] exp_q[$];
	int bad_count = 0, samples_checked = 0;
	event go;
	hpi_host_model i_host (.clk(clk), .sa_n(sa_n), .sb_n(sb_n), .ad(ad), .rd_n(rs_n));
	hpi_irq_latch i_dut (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_CE(ce),
		.I_INPUT_FULL_IRQ_EN_A(irq_in[3]), .I_INPUT_FULL_IRQ_EN_B(irq_in[2]),
		.I_HOST_IN_REG_A_FULL(irq_in[1]), .I_HOST_IN_REG_B_FULL(irq_in[0]),
		.I_HOST_IFACE_ENABLE(host_iface_enable), .I_PORT_WR(wr), .I_PORT_WDATA(wd), .I_PORT_RD(rd),
		.I_HOST_SELECT_A_N(sa_n), .I_HOST_SELECT_B_N(sb_n), .I_HOST_ADDR_BIT(ad),
		.I_HOST_READ_STROBE_N(rs_n), .O_INPUT_FULL_IRQ_A(got[12]), .O_INPUT_FULL_IRQ_B(got[11]),
		.O_PORT_RDATA(got[7:0]), .O_HOST_REQ_LATCH_B(got[10]), .O_HOST_REQ_LATCH_A0(got[9]),
		.O_HOST_REQ_LATCH_A1(got[8]));
	initial forever #2 clk = ~clk;
	task automatic step(int n);
		repeat (n) @(negedge clk);
	endtask
	// Slave read (w=0) or write (w=1) lasting one cycle
	task automatic pulse(logic w, logic [7:0] d);
		@(negedge clk) {wr, rd, wd} = {w, !w, d};
		@(negedge clk) {wr, rd} = 2'h0;
	endtask
	// Flags and latches in e, last slave read data in r
	task automatic ck(logic [4:0] e, logic [7:0] r);
		step(6);
		exp_q.push_back({e, r});
		->go;
	endtask
	always @(go)
	begin
		samples_checked++;
		if (got !== exp_q[0])
		begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp_q[0]);
		end
		void'(exp_q.pop_front());
	end
	task automatic wrap_up();
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		bad_count++;
		wrap_up();
	end
	initial
	begin
		void'($urandom(75));
		step(8);
		rstn = 1'b1;
		repeat (8)
		begin
			irq_in = 4'($urandom);
			ck({irq_in[3] & irq_in[1], irq_in[2] & irq_in[0], 3'h0}, 8'h00);
		end
		irq_in = 4'h0;
		host_iface_enable = 1'b1;
		pulse(1'b0, 8'h00);
		pulse(1'b1, 8'h38);
		ck(5'h07, 8'h00);
		pulse(1'b0, 8'h00);
		ck(5'h07, 8'h38);
		pulse(1'b1, 8'h00);
		pulse(1'b1, 8'h39);
		ck(5'h00, 8'h38);
		pulse(1'b0, 8'h00);
		pulse(1'b1, 8'h38);
		i_host.rd(1'b0, 1'b1);
		ck(5'h07, 8'h01);
		i_host.rd(1'b0, 1'b0);
		ck(5'h04, 8'h01);
		i_host.rd(1'b1, 1'b0);
		ck(5'h00, 8'h01);
		host_iface_enable = 1'b0;
		pulse(1'b1, 8'h08);
		i_host.rd(1'b1, 1'b0);
		ck(5'h04, 8'h01);
		ce = 1'b0;
		pulse(1'b1, 8'h00);
		ce = 1'b1;
		ck(5'h04, 8'h01);
		rstn = 1'b0;
		step(2);
		rstn = 1'b1;
		ck(5'h00, 8'h00);
		wrap_up();
	end
endmodule
`default_nettype wire
